// ---- include/nrp_pkg.sv ----
//Contract
//R1: A full-row program erases the addressed row, then programs supplied bytes.
//R2: Flash or EEPROM target chosen from array id alone; ids run sequentially per type.
//R3: With ECC on, a flash array is 256 rows of 256 data bytes.
//R4: With ECC off, a full flash row is 288 bytes: data then ECC, staged in buffer.
//R5: An EEPROM array is 128 rows of 16 bytes; one row per write.
//R6: Data-only flash write with ECC on generates and writes the ECC bytes.
//R7: Data-only flash write with ECC off leaves the row's ECC bytes untouched.
//R8: ECC-only write programs just the 32-byte ECC part of a flash row.
//R9: ECC-only writes accepted only for flash, ECC off, ECC not holding config.
//R10: With config in ECC area, requester sends data and ECC in one full write.
//R11: New request while writing answers busy; unaccepted command rejected; else failure.
//R12: Requester supplies die temperature before a series of row writes.
//R13: Flash disable ignored while processor runs; applies once it stops.
//R14: Flash enabled after reset; early silicon shares one enable for flash and EEPROM.
//R15: Later silicon: EEPROM has own enable and is unusable until set.
//R16: Controller holds flash wait-cycle setting; requester orders it around clock changes.
//R17: EEPROM access arbitrated; read reservation waits until granted.
//R18: Unreserved EEPROM read during an active write raises a fault; data invalid.
//R19: While reservation held, EEPROM writes blocked; requester releases first.
//R20: Requester keeps row data source apart from the staging buffer.
//R21: Busy shown until erase-program or temperature operation fully completes.
`default_nettype none
package nrp_pkg;
	// Register byte addresses
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_CFG = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_RESV = 8'h0c;
	localparam logic [7:0] A_BUF = 8'h10;
	// Field positions
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_ID_LSB = 8;
	localparam int CMD_ROW_LSB = 16;
	localparam int CFG_ECC_EN = 0;
	localparam int CFG_ECC_CFG = 1;
	localparam int CFG_FLASH_EN = 2;
	localparam int CFG_EE_EN = 3;
	localparam int CFG_WAIT_LSB = 8;
	localparam int CFG_TEMP_LSB = 16;
	localparam int STAT_FAULT = 3;
	localparam int BUF_IDX_LSB = 16;
	// Reset values
	localparam logic RST_ECC_EN = 1'b1;
	localparam logic RST_FLASH_EN = 1'b1;
	localparam logic RST_EE_EN = 1'b0;
	localparam logic [3:0] RST_WAIT = 4'h3;
	// Geometry
	localparam logic [8:0] FLASH_ROW_BYTES = 9'h100;
	localparam logic [8:0] ECC_ROW_BYTES = 9'h020;
	localparam logic [8:0] FULL_ROW_BYTES = 9'h120;
	localparam logic [8:0] EEPROM_ROW_BYTES = 9'h010;
	localparam logic [8:0] FLASH_ROWS = 9'h100;
	localparam logic [8:0] EE_ROWS = 9'h080;
	localparam int ECC_GROUP = 8;
	// Operations, status codes, program areas
	localparam logic [1:0] OP_FULL = 2'h0;
	localparam logic [1:0] OP_DATA = 2'h1;
	localparam logic [1:0] OP_ECC = 2'h2;
	localparam logic [1:0] OP_TEMP = 2'h3;
	localparam logic [1:0] ST_OK = 2'h0;
	localparam logic [1:0] ST_WRITE_BUSY = 2'h1;
	localparam logic [1:0] ST_REJECTED = 2'h2;
	localparam logic [1:0] ST_FAILURE = 2'h3;
	localparam logic [1:0] AREA_ROW = 2'h0;
	localparam logic [1:0] AREA_DATA = 2'h1;
	localparam logic [1:0] AREA_ECC = 2'h2;
endpackage
`default_nettype wire

// ---- hw/nrp_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module nrp_ctrl #(
	parameter int N_FLASH = 1,
	parameter int N_EE = 1,
	parameter logic [7:0] ARRAY_ID_A = 8'h00,
	parameter logic [7:0] FIRST_EEPROM_ARRAY_ID = 8'h40,
	parameter bit EARLY_SILICON = 1'b0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic cpu_run,
	input wire logic ee_rd,
	output logic ee_rd_bad,
	output logic flash_on,
	output logic ee_on,
	output logic [3:0] flash_wait,
	output logic busy,
	output logic nv_erase,
	output logic nv_temp,
	output logic [7:0] nv_temp_val,
	output logic nv_wr,
	output logic nv_is_ee,
	output logic [7:0] nv_id,
	output logic [8:0] nv_row,
	output logic [1:0] nv_area,
	output logic [8:0] nv_idx,
	output logic [7:0] nv_wdata,
	input wire logic nv_done,
	input wire logic nv_fail
);
	import nrp_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_ERASE, S_EWAIT, S_PROG, S_PWAIT} nrp_state_t;

	nrp_state_t state_r;
	logic wr_pend_r;
	logic [7:0] addr_r;
	logic [1:0] status_r;
	logic ecc_en_r, ecc_cfg_r, flash_req_r, ee_en_r, resv_r, grant_r, fault_r, gen_r;
	logic [3:0] wait_r;
	logic [7:0] temp_r;
	logic [8:0] idx_r, last_r;
	logic [7:0] buf_r [0:287];

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic ap, cmd_wr;
	assign ap = hsel & htrans[1] & hready;
	assign cmd_wr = wr_pend_r && addr_r == A_CMD;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_pend_r <= 1'b0;
			addr_r <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_r <= ap & hwrite;
			if (ap) begin
				addr_r <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hrdata <= 32'h00000000;
		end else if (ap && !hwrite) begin
			case (haddr[7:0])
				A_CFG: hrdata <= {8'h00, temp_r, 4'h0, wait_r, 4'h0, ee_en_r, flash_req_r, ecc_cfg_r, ecc_en_r};
				A_STAT: hrdata <= {27'h0000000, grant_r, fault_r, status_r, busy};
				A_RESV: hrdata <= {31'h00000000, resv_r};
				A_CMD: hrdata <= {7'h00, nv_row, nv_id, 6'h00, nv_area};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Configuration and enables
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ecc_en_r <= RST_ECC_EN;
			ecc_cfg_r <= 1'b0;
			flash_req_r <= RST_FLASH_EN;
			ee_en_r <= RST_EE_EN;
			wait_r <= RST_WAIT;
			temp_r <= 8'h00;
		end else if (wr_pend_r && addr_r == A_CFG) begin
			ecc_en_r <= hwdata[CFG_ECC_EN];
			ecc_cfg_r <= hwdata[CFG_ECC_CFG];
			flash_req_r <= hwdata[CFG_FLASH_EN];
			ee_en_r <= hwdata[CFG_EE_EN];
			wait_r <= hwdata[CFG_WAIT_LSB +: 4]; // R16
			temp_r <= hwdata[CFG_TEMP_LSB +: 8]; // R12
		end
	end

	// Stop is parked until the processor halts, so code never loses its fetch path
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flash_on <= RST_FLASH_EN; // R14
			ee_on <= EARLY_SILICON ? RST_FLASH_EN : RST_EE_EN; // R14 R15
			flash_wait <= RST_WAIT;
			nv_temp_val <= 8'h00;
		end else begin
			if (flash_req_r) begin
				flash_on <= 1'b1;
			end else if (!cpu_run) begin
				flash_on <= 1'b0; // R13
			end
			ee_on <= EARLY_SILICON ? flash_on : ee_en_r; // R14 R15
			flash_wait <= wait_r; // R16
			nv_temp_val <= temp_r;
		end
	end

	// ------------------------------------------------------------
	// Read reservation and fault
	// ------------------------------------------------------------
	logic ee_writing;
	assign ee_writing = busy && nv_is_ee;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			resv_r <= 1'b0;
			grant_r <= 1'b0;
			fault_r <= 1'b0;
			ee_rd_bad <= 1'b0;
		end else begin
			if (wr_pend_r && addr_r == A_RESV) begin
				resv_r <= hwdata[0];
			end
			// Grant only between writes; held until released
			grant_r <= resv_r && (grant_r || !ee_writing); // R17
			ee_rd_bad <= ee_rd && !grant_r && ee_writing; // R18
			// Set beats a same-cycle clear
			if (ee_rd && !grant_r && ee_writing) begin
				fault_r <= 1'b1; // R18
			end else if (wr_pend_r && addr_r == A_STAT && hwdata[STAT_FAULT]) begin
				fault_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Staging buffer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (wr_pend_r && addr_r == A_BUF && hwdata[BUF_IDX_LSB +: 9] < FULL_ROW_BYTES) begin
			buf_r[hwdata[BUF_IDX_LSB +: 9]] <= hwdata[7:0]; // R4
		end
	end

	function automatic logic [7:0] ecc_of(input logic [8:0] i);
		logic [7:0] x;
		x = 8'h00;
		for (int k = 0; k < ECC_GROUP; k++) begin
			x = x ^ buf_r[{1'b0, i[4:0], k[2:0]}];
		end
		return x;
	endfunction

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	logic [1:0] c_op;
	logic [7:0] c_id;
	logic [8:0] c_row;
	logic c_fl, c_ee, c_ok;
	assign c_op = hwdata[CMD_OP_LSB +: 2];
	assign c_id = hwdata[CMD_ID_LSB +: 8];
	assign c_row = hwdata[CMD_ROW_LSB +: 9];
	assign c_fl = c_id >= ARRAY_ID_A && 32'(c_id) < 32'(ARRAY_ID_A) + N_FLASH; // R2
	assign c_ee = c_id >= FIRST_EEPROM_ARRAY_ID && 32'(c_id) < 32'(FIRST_EEPROM_ARRAY_ID) + N_EE; // R2

	always_comb begin
		c_ok = 1'b1;
		if (c_op != OP_TEMP) begin
			if (c_fl) begin
				c_ok = flash_on && c_row < FLASH_ROWS; // R3
			end else if (c_ee) begin
				c_ok = ee_on && c_row < EE_ROWS && !resv_r && c_op != OP_ECC; // R5 R15 R19 R9
			end else begin
				c_ok = 1'b0;
			end
			if (c_op == OP_ECC && (ecc_en_r || ecc_cfg_r)) begin
				c_ok = 1'b0; // R9
			end
		end
	end

	// ------------------------------------------------------------
	// Erase and program engine
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= S_IDLE;
			status_r <= ST_OK;
			busy <= 1'b0;
			nv_erase <= 1'b0;
			nv_temp <= 1'b0;
			nv_wr <= 1'b0;
			nv_is_ee <= 1'b0;
			nv_id <= 8'h00;
			nv_row <= 9'h000;
			nv_area <= AREA_ROW;
			nv_idx <= 9'h000;
			nv_wdata <= 8'h00;
			idx_r <= 9'h000;
			last_r <= 9'h000;
			gen_r <= 1'b0;
		end else begin
			nv_erase <= 1'b0;
			nv_temp <= 1'b0;
			nv_wr <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (cmd_wr) begin
						if (!c_ok) begin
							status_r <= ST_REJECTED; // R11
						end else if (c_op == OP_TEMP) begin
							nv_temp <= 1'b1; // R12
							// Not an EEPROM write: reads and grants stay free
							nv_is_ee <= 1'b0;
							busy <= 1'b1;
							state_r <= S_PWAIT;
						end else begin
							busy <= 1'b1;
							nv_is_ee <= c_ee;
							nv_id <= c_id;
							nv_row <= c_row;
							gen_r <= c_fl && ecc_en_r; // R6
							nv_area <= AREA_ROW;
							idx_r <= 9'h000;
							last_r <= c_ee ? EEPROM_ROW_BYTES - 9'h001 : FULL_ROW_BYTES - 9'h001; // R4 R5
							if (c_fl && c_op == OP_DATA && !ecc_en_r) begin
								nv_area <= AREA_DATA; // R7
								last_r <= FLASH_ROW_BYTES - 9'h001;
							end
							if (c_op == OP_ECC) begin
								nv_area <= AREA_ECC; // R8
								idx_r <= FLASH_ROW_BYTES;
							end
							state_r <= S_ERASE;
						end
					end
				end
				S_ERASE: begin
					nv_erase <= 1'b1; // R1
					state_r <= S_EWAIT;
				end
				S_EWAIT: begin
					if (nv_done) begin
						state_r <= nv_fail ? S_IDLE : S_PROG;
						busy <= !nv_fail;
						status_r <= nv_fail ? ST_FAILURE : status_r;
					end
				end
				S_PROG: begin
					nv_wr <= 1'b1; // R1
					nv_idx <= idx_r;
					nv_wdata <= (gen_r && idx_r >= FLASH_ROW_BYTES) ? ecc_of(idx_r) : buf_r[idx_r]; // R6
					idx_r <= idx_r + 9'h001;
					if (idx_r == last_r) begin
						state_r <= S_PWAIT;
					end
				end
				S_PWAIT: begin
					if (nv_done) begin
						state_r <= S_IDLE;
						busy <= 1'b0; // R21
						status_r <= nv_fail ? ST_FAILURE : ST_OK; // R11
					end
				end
				default: state_r <= S_IDLE;
			endcase
			if (cmd_wr && state_r != S_IDLE) begin
				status_r <= ST_WRITE_BUSY; // R11
			end
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_busy_lock: assert property (@(posedge clk) disable iff (!resetn) // R11
		cmd_wr && state_r != S_IDLE && !nv_done |=> status_r == ST_WRITE_BUSY && busy)
		else $error("busy request not answered locked");
	a_ecc_ee_rej: assert property (@(posedge clk) disable iff (!resetn) // R9
		cmd_wr && state_r == S_IDLE && c_ee && c_op == OP_ECC |=> status_r == ST_REJECTED && !busy)
		else $error("ecc write to eeprom accepted");
	a_erase_first: assert property (@(posedge clk) disable iff (!resetn) // R1
		$rose(nv_wr) |-> $past(state_r, 2) == S_EWAIT)
		else $error("program without erase");
	a_ee_row: assert property (@(posedge clk) disable iff (!resetn) // R5
		nv_wr && nv_is_ee |-> nv_idx < EEPROM_ROW_BYTES)
		else $error("eeprom byte beyond row");
	a_keep_ecc: assert property (@(posedge clk) disable iff (!resetn) // R7
		nv_wr && nv_area == AREA_DATA |-> nv_idx < FLASH_ROW_BYTES)
		else $error("data write touched ecc area");
	a_ecc_only: assert property (@(posedge clk) disable iff (!resetn) // R8
		nv_wr && nv_area == AREA_ECC |-> nv_idx >= FLASH_ROW_BYTES && nv_idx < FULL_ROW_BYTES)
		else $error("ecc write outside ecc area");
	a_flash_hold: assert property (@(posedge clk) disable iff (!resetn) // R13
		cpu_run && flash_on |=> flash_on)
		else $error("flash stopped while cpu runs");
	a_read_fault: assert property (@(posedge clk) disable iff (!resetn) // R18
		ee_rd && !grant_r && ee_writing |=> fault_r && ee_rd_bad)
		else $error("unreserved read not faulted");
	a_resv_block: assert property (@(posedge clk) disable iff (!resetn) // R19
		cmd_wr && state_r == S_IDLE && resv_r && c_ee && c_op != OP_TEMP |=> status_r == ST_REJECTED)
		else $error("eeprom write taken under reservation");
	a_grant_safe: assert property (@(posedge clk) disable iff (!resetn) // R17
		$rose(grant_r) |-> $past(resv_r) && !$past(ee_writing))
		else $error("grant given during eeprom write");
	a_busy_span: assert property (@(posedge clk) disable iff (!resetn) // R21
		state_r != S_IDLE && !(nv_done && (state_r == S_PWAIT || (state_r == S_EWAIT && nv_fail))) |=> busy)
		else $error("idle before operation completed");
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
	import nrp_pkg::*;
	localparam logic [7:0] FL = 8'h00;
	localparam logic [7:0] EE = 8'h40;
	localparam logic [18:0] MK = 19'h7ffff;
	logic clk = '0, resetn = '0, hsel = '0, hwrite = '0, cpu_run = '0, ee_rd = '0, nv_done = '0, nv_fail = '0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
	logic [1:0] htrans = '0, nv_area;
	logic [2:0] hsize = 3'h2;
	wire logic hrdy;
	logic hresp, ee_rd_bad, flash_on, ee_on, busy, nv_erase, nv_temp, nv_wr, nv_is_ee, wr_d = '0, saw_bad = '0;
	logic [3:0] flash_wait;
	logic [7:0] nv_temp_val, nv_id, nv_wdata, t;
	logic [8:0] nv_row, nv_idx;
	logic [7:0] bm [288];
	logic [18:0] wq [$];
	logic [31:0] rej [6];
	int n_fail = 0, checks = 0, dcnt = 0;

	nrp_ctrl #(.ARRAY_ID_A(FL), .FIRST_EEPROM_ARRAY_ID(EE)) DUT (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hrdy), .hreadyout(hrdy), .hresp, .hrdata, .cpu_run, .ee_rd, .ee_rd_bad, .flash_on,
		.ee_on, .flash_wait, .busy, .nv_erase, .nv_temp, .nv_temp_val, .nv_wr, .nv_is_ee, .nv_id, .nv_row, .nv_area,
		.nv_idx, .nv_wdata, .nv_done, .nv_fail);

	always #50 clk = ~clk;

	// ----------------------------------------
	// Array side and trace
	// ----------------------------------------
	// Random done delay of 3 to 8 cycles, always landing in a wait state, so short and long waits both get exercised
	always @(posedge clk) begin
		wr_d <= nv_wr;
		nv_done <= (dcnt == 1);
		if (ee_rd_bad === 1'h1) saw_bad <= 1'h1;
		if (dcnt > 0) dcnt <= dcnt - 1;
		else if ((nv_erase | nv_temp | (wr_d & !nv_wr)) === 1'h1) dcnt <= 3 + $urandom % 6;
		if ((nv_erase | nv_temp) === 1'h1) wq.push_back(nv_temp ? {11'h7fe, nv_temp_val} : MK);
		else if (nv_wr === 1'h1) wq.push_back({nv_area, nv_idx, nv_wdata});
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hrdy !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'h1);
		r = hrdata;
	endtask

	function automatic logic [31:0] cmd(logic [1:0] op, logic [7:0] id, logic [8:0] row);
		return {7'h0, row, id, 6'h0, op};
	endfunction

	function automatic logic [7:0] exp_b(int i, logic gen);
		logic [7:0] x;
		x = bm[i];
		if (gen && i >= 256) begin
			x = 8'h0;
			for (int j = 0; j < 8; j++) x ^= bm[8 * (i - 256) + j];
		end
		return x;
	endfunction

	task cfg(input logic ecc, ecfg, fl, ee, input logic [3:0] wt, input logic [7:0] tmp);
		bus(1'h1, A_CFG, {8'h0, tmp, 4'h0, wt, 4'h0, ee, fl, ecfg, ecc});
		repeat (2) @(posedge clk);
	endtask

	task fill(input int lo, input int hi);
		for (int i = lo; i < hi; i++) begin
			bm[i] = 8'($urandom);
			bus(1'h1, A_BUF, {7'h0, 9'(i), 8'h0, bm[i]});
		end
	endtask

	task go(input logic [31:0] c);
		wq.delete();
		bus(1'h1, A_CMD, c);
	endtask

	// Trace holds the erase or temperature marker first, then every byte
	task fin(input int lo, hi, input logic gen, input logic [1:0] ar, input logic [18:0] mk, input logic [1:0] st);
		int n;
		do bus(1'h0, A_STAT, '0); while (r[0] !== 1'h0);
		n = (st == ST_REJECTED) ? 0 : hi - lo + 1;
		chk(r[2:1], st);
		chk(busy, 1'h0);
		chk(wq.size(), n);
		foreach (wq[i]) chk(wq[i], i == 0 ? mk : {ar, 9'(lo + i - 1), exp_b(lo + i - 1, gen)});
	endtask

	task run(input logic [31:0] c, input int lo, hi, input logic gen, input logic [1:0] ar, input logic [18:0] mk,
		input logic [1:0] st);
		go(c);
		fin(lo, hi, gen, ar, mk, st);
		if (st != ST_REJECTED) chk({nv_is_ee, nv_id, nv_row}, {c[15:8] == EE, c[15:8], c[24:16]});
	endtask

	task done(input string s);
		$display("test %s finished", s);
	endtask

	task report_and_stop;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (30000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end

	initial begin
		rej = '{cmd(OP_FULL, 8'h01, 9'h0), cmd(OP_FULL, 8'h41, 9'h0), cmd(OP_FULL, FL, 9'h100),
			cmd(OP_FULL, EE, 9'h080), cmd(OP_ECC, FL, 9'h005), cmd(OP_ECC, EE, 9'h0)};
		void'($urandom(77));
		repeat (4) @(posedge clk);
		resetn <= 1'h1;
		bus(1'h0, A_CFG, '0);
		chk(r, 32'h0000_0305);
		chk({hresp, flash_on, ee_on, flash_wait}, 7'h23);
		bus(1'h1, 8'h20, 32'hffff_ffff);
		bus(1'h0, 8'h20, '0);
		chk(r, '0);
		done("reset");
		t = 8'($urandom);
		cfg(1'h1, 1'h0, 1'h1, 1'h0, 4'h3, t);
		go(cmd(OP_TEMP, FL, 9'h0));
		bus(1'h0, A_STAT, '0);
		chk(r[0], 1'h1);
		fin(0, 0, 1'h0, AREA_ROW, {11'h7fe, t}, ST_OK);
		done("temp");
		run(cmd(OP_FULL, EE, 9'h0), 0, 0, 1'h0, AREA_ROW, MK, ST_REJECTED);
		cfg(1'h1, 1'h0, 1'h1, 1'h1, 4'h3, t);
		chk(ee_on, 1'h1);
		foreach (rej[i]) run(rej[i], 0, 0, 1'h0, AREA_ROW, MK, ST_REJECTED);
		done("reject");
		fill(0, 256);
		run(cmd(OP_DATA, FL, 9'($urandom % 256)), 0, 288, 1'h1, AREA_ROW, MK, ST_OK);
		cfg(1'h0, 1'h0, 1'h1, 1'h1, 4'h3, t);
		fill(256, 288);
		run(cmd(OP_FULL, FL, 9'h0ff), 0, 288, 1'h0, AREA_ROW, MK, ST_OK);
		run(cmd(OP_DATA, FL, 9'h001), 0, 256, 1'h0, AREA_DATA, MK, ST_OK);
		fill(256, 288);
		run(cmd(OP_ECC, FL, 9'h002), 256, 288, 1'h0, AREA_ECC, MK, ST_OK);
		cfg(1'h0, 1'h1, 1'h1, 1'h1, 4'h3, t);
		run(cmd(OP_ECC, FL, 9'h002), 0, 0, 1'h0, AREA_ROW, MK, ST_REJECTED);
		run(cmd(OP_FULL, FL, 9'h004), 0, 288, 1'h0, AREA_ROW, MK, ST_OK);
		nv_fail <= 1'h1;
		run(cmd(OP_FULL, FL, 9'h003), 0, 0, 1'h0, AREA_ROW, MK, ST_FAILURE);
		nv_fail <= 1'h0;
		done("flash");
		fill(0, 16);
		go(cmd(OP_FULL, EE, 9'h07f));
		bus(1'h1, A_CMD, cmd(OP_TEMP, FL, 9'h0));
		bus(1'h0, A_STAT, '0);
		chk(r[2:0], 3'h3);
		@(posedge clk) ee_rd <= 1'h1;
		@(posedge clk) ee_rd <= 1'h0;
		fin(0, 16, 1'h0, AREA_ROW, MK, ST_OK);
		chk({r[3], saw_bad}, 2'h3);
		bus(1'h1, A_STAT, 32'h8);
		bus(1'h0, A_STAT, '0);
		chk(r[3], 1'h0);
		done("eeprom");
		go(cmd(OP_FULL, EE, 9'h010));
		bus(1'h1, A_RESV, 32'h1);
		bus(1'h0, A_STAT, '0);
		chk({r[4], r[0]}, 2'h1);
		fin(0, 16, 1'h0, AREA_ROW, MK, ST_OK);
		repeat (2) @(posedge clk);
		bus(1'h0, A_STAT, '0);
		chk(r[4], 1'h1);
		run(cmd(OP_FULL, EE, 9'h010), 0, 0, 1'h0, AREA_ROW, MK, ST_REJECTED);
		bus(1'h1, A_RESV, '0);
		repeat (2) @(posedge clk);
		bus(1'h0, A_STAT, '0);
		chk(r[4], 1'h0);
		done("reserve");
		cpu_run <= 1'h1;
		cfg(1'h1, 1'h0, 1'h0, 1'h1, 4'h7, t);
		chk({flash_on, flash_wait}, 5'h17);
		cpu_run <= 1'h0;
		repeat (2) @(posedge clk);
		chk(flash_on, 1'h0);
		cfg(1'h1, 1'h0, 1'h1, 1'h1, 4'h3, t);
		chk({flash_on, flash_wait}, 5'h13);
		done("enable");
		report_and_stop();
	end
endmodule
`default_nettype wire
